// ===== design/rmc_pkg.sv
package rmc_pkg;
  // frame and port geometry
  localparam int unsigned RMC_DATA_BITS = 8;
  localparam int unsigned RMC_NUM_PORTS = 8;
  // opcodes, MSB left
  localparam logic [7:0] RMC_OP_OPTIONS_MASK = 8'hfc;
  localparam logic [7:0] RMC_OP_OPTIONS = 8'h08;
  localparam logic [7:0] RMC_OP_ALT_AUI_PART = 8'h1f;
  localparam logic [7:0] RMC_OP_ALT_TP_PART = 8'h10;
  localparam logic [7:0] RMC_OP_AUI_DISABLE = 8'h2f;
  localparam logic [7:0] RMC_OP_AUI_ENABLE = 8'h3f;
  localparam logic [7:0] RMC_OP_PORT_MASK = 8'hf8;
  localparam logic [7:0] RMC_OP_TP_DISABLE = 8'h20;
  localparam logic [7:0] RMC_OP_TP_ENABLE = 8'h30;
  localparam logic [7:0] RMC_OP_LT_DISABLE = 8'h40;
  localparam logic [7:0] RMC_OP_LT_ENABLE = 8'h50;
  localparam logic [7:0] RMC_OP_POL_DISABLE = 8'h60;
  localparam logic [7:0] RMC_OP_POL_ENABLE = 8'h70;
  localparam logic [7:0] RMC_OP_AUI_ST_BSL = 8'h8f;
  localparam logic [7:0] RMC_OP_AUI_ST_SL = 8'h8b;
  localparam logic [7:0] RMC_OP_AUI_ST_B = 8'h8d;
  localparam logic [7:0] RMC_OP_AUI_ST_NONE = 8'h89;
  localparam logic [7:0] RMC_OP_PART_ST = 8'h80;
  localparam logic [7:0] RMC_OP_RATE_ST = 8'ha0;
  localparam logic [7:0] RMC_OP_LINK_ST = 8'hd0;
  localparam logic [7:0] RMC_OP_POL_ST = 8'he0;
  // option bit positions
  localparam int unsigned RMC_OPT_SQE_BIT = 1;
  localparam int unsigned RMC_OPT_CAM_BIT = 0;
  // aui flag positions within aui_status_flags (P,B,S,L)
  localparam int unsigned RMC_FLAG_B = 2;
  localparam int unsigned RMC_FLAG_S = 1;
  localparam int unsigned RMC_FLAG_L = 0;
  // reset values
  localparam logic [7:0] RMC_RST_PORT_EN = 8'hff;
  localparam logic [7:0] RMC_RST_LT_EN = 8'hff;
  localparam logic [7:0] RMC_RST_POL_EN = 8'h00;
  localparam logic RMC_RST_SO = 1'b1;
  // last bit index of a received byte and of a sent frame
  localparam logic [3:0] RMC_LAST_RX_BIT = 4'h7;
  localparam logic [3:0] RMC_LAST_TX_BIT = 4'h8;

  typedef enum logic [1:0] {
    RMC_IDLE = 2'b00,
    RMC_RECV = 2'b01,
    RMC_SEND = 2'b10
  } rmc_state_e;
endpackage : rmc_pkg

// ===== design/rmc_mgmt_port.sv
// Summary of operation
// - commands accepted only while the test-select strap is low
// - commands arrive serially on the input; responses leave on the output
// - both directions sampled and advanced on shift clock rising edge
// - every byte framed as one start bit then eight data bits
// - data shifted least significant bit first
// - options command latches sqe-test mask and unmasked activity monitor
// - alternate aui partition command holds until reset
// - alternate tp partition command switches all ports until reset
// - per-port link-test disable and enable opcodes
// - per-port polarity-correction disable and enable opcodes
// - full aui status read returns flags, then clears b, s, l
// - three more aui reads clear s and l, b only, or nothing
// - partition status read returns one bit per port
// - bit-rate status read returns one bit per port
// - link status read returns one bit per port
// - polarity status read returns one bit per port
// - aui disable idles aui partition machine and stops aui traffic
// - aui enable re-enables aui; all ports enabled after reset
// - tp disable idles partition machine; tp enable forces link fail on ports that were disabled
// - select codes map directly on eight ports, odd codes on four
module rmc_mgmt_port #(
  parameter bit FOUR_PORT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic test_sel,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  // aui status inputs: b, s, l events and partition level
  input wire logic aui_connected,
  input wire logic aui_b_event,
  input wire logic aui_s_event,
  input wire logic aui_l_event,
  // per-port status inputs
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_partitioned,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_rate_status,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_link_status,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_pol_status,
  // configuration outputs
  output logic sqe_test_mask,
  output logic carrier_activity_monitor,
  output logic aui_alt_partition,
  output logic tp_alt_partition,
  output logic aui_enable,
  output logic aui_part_idle,
  output logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_enable,
  output logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_part_idle,
  output logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_force_link_fail,
  output logic [rmc_pkg::RMC_NUM_PORTS-1:0] link_test_enable,
  output logic [rmc_pkg::RMC_NUM_PORTS-1:0] pol_corr_enable
);
  import rmc_pkg::*;

  // port select decode; on four-port parts even codes select nothing
  function automatic logic [RMC_NUM_PORTS-1:0] port_sel(input logic [2:0] code);
    logic [RMC_NUM_PORTS-1:0] sel;
    sel = '0;
    if (!FOUR_PORT) begin
      sel[code] = 1'b1;
    end else if (code[0]) begin
      sel[{1'b0, code[2:1]}] = 1'b1;
    end
    return sel;
  endfunction : port_sel

  // mask of ports present on this version
  function automatic logic [7:0] port_mask(input logic [7:0] v);
    return FOUR_PORT ? {4'h0, v[3:0]} : v;
  endfunction : port_mask

  // pin synchronisers
  logic [2:0] sclk_sync;
  logic [1:0] si_sync;
  logic [1:0] test_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync <= 3'h0;
      si_sync <= 2'h3;
      test_sync <= 2'h3;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      si_sync <= {si_sync[0], si};
      test_sync <= {test_sync[0], test_sel};
    end
  end

  // rise judged on the two settled stages only
  // third sclk stage feeds only the edge detector
  logic sclk_rise;
  logic port_active;
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign port_active = ~test_sync[1];

  rmc_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [8:0] tx_shift;
  logic cmd_done;
  logic [7:0] cmd;
  logic [7:0] next_cmd;

  // lsb arrives first, so each new bit enters at the top
  assign next_cmd = {si_sync[1], rx_shift[7:1]};
  assign cmd_done = (state == RMC_RECV) && sclk_rise && (bit_cnt == RMC_LAST_RX_BIT);

  // aui flags: p is a live level, b/s/l sticky
  logic flag_b;
  logic flag_s;
  logic flag_l;

  // response byte for a read opcode; valid flag marks assigned reads
  logic resp_valid;
  logic [7:0] resp;
  always_comb begin
    resp_valid = 1'b1;
    resp = 8'h00;
    unique case (next_cmd)
      RMC_OP_AUI_ST_BSL, RMC_OP_AUI_ST_SL, RMC_OP_AUI_ST_B, RMC_OP_AUI_ST_NONE: begin
        resp = {aui_connected, flag_b, flag_s, flag_l, 4'h0};
      end
      RMC_OP_PART_ST: resp = port_mask(tp_partitioned);
      RMC_OP_RATE_ST: resp = port_mask(tp_rate_status);
      RMC_OP_LINK_ST: resp = port_mask(tp_link_status);
      RMC_OP_POL_ST: resp = port_mask(tp_pol_status);
      default: resp_valid = 1'b0;
    endcase
  end

  // serial framing state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RMC_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 9'h1ff;
      so <= RMC_RST_SO;
    end else if (!port_active) begin
      // strap raised mid-frame drops the partial byte
      state <= RMC_IDLE;
      bit_cnt <= 4'h0;
      so <= RMC_RST_SO;
    end else if (sclk_rise) begin
      unique case (state)
        RMC_IDLE: begin
          if (!si_sync[1]) begin
            state <= RMC_RECV;
            bit_cnt <= 4'h0;
          end
          so <= RMC_RST_SO;
        end
        RMC_RECV: begin
          rx_shift <= next_cmd;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == RMC_LAST_RX_BIT) begin
            // flags captured here, on the same clock edge that applies their clear
            if (resp_valid) begin
              state <= RMC_SEND;
              so <= 1'b0;
              tx_shift <= {1'b1, resp};
              bit_cnt <= 4'h0;
            end else begin
              state <= RMC_IDLE;
            end
          end
        end
        RMC_SEND: begin
          so <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[8:1]};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == RMC_LAST_TX_BIT) begin
            state <= RMC_IDLE; // line returns high after the last bit
          end
        end
        default: state <= RMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= 8'h00;
    end else if (cmd_done) begin
      cmd <= next_cmd;
    end
  end

  // one-cycle strobe for write opcodes decoded from the completed byte
  // exec trails cmd_done by one clock, so cmd already holds the byte
  logic exec;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exec <= 1'b0;
    end else begin
      exec <= cmd_done && port_active;
    end
  end

  // decoded from the held byte, so it stays steady while exec is high
  logic [RMC_NUM_PORTS-1:0] sel;
  assign sel = port_sel(cmd[2:0]);

  // option and partition algorithm settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sqe_test_mask <= 1'b0;
      carrier_activity_monitor <= 1'b0;
      aui_alt_partition <= 1'b0;
      tp_alt_partition <= 1'b0;
    end else if (exec) begin
      if ((cmd & RMC_OP_OPTIONS_MASK) == RMC_OP_OPTIONS) begin
        sqe_test_mask <= cmd[RMC_OPT_SQE_BIT];
        carrier_activity_monitor <= cmd[RMC_OPT_CAM_BIT];
      end
      if (cmd == RMC_OP_ALT_AUI_PART) begin
        aui_alt_partition <= 1'b1;
      end
      if (cmd == RMC_OP_ALT_TP_PART) begin
        tp_alt_partition <= 1'b1;
      end
    end
  end

  // aui enable and partition idle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aui_enable <= 1'b1;
      aui_part_idle <= 1'b0;
    end else begin
      aui_part_idle <= 1'b0;
      if (exec && cmd == RMC_OP_AUI_DISABLE) begin
        aui_enable <= 1'b0;
        aui_part_idle <= 1'b1;
      end
      if (exec && cmd == RMC_OP_AUI_ENABLE) begin
        aui_enable <= 1'b1;
      end
    end
  end

  // per-port enables; pulses last one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tp_enable <= RMC_RST_PORT_EN;
      tp_part_idle <= '0;
      tp_force_link_fail <= '0;
    end else begin
      tp_part_idle <= '0;
      tp_force_link_fail <= '0;
      if (exec && (cmd & RMC_OP_PORT_MASK) == RMC_OP_TP_DISABLE) begin
        tp_enable <= tp_enable & ~sel;
        tp_part_idle <= sel;
      end
      if (exec && (cmd & RMC_OP_PORT_MASK) == RMC_OP_TP_ENABLE) begin
        tp_enable <= tp_enable | sel;
        // link fail only for ports that really were disabled
        tp_force_link_fail <= sel & ~tp_enable;
      end
    end
  end

  // link-test and polarity-correction enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_test_enable <= RMC_RST_LT_EN;
      pol_corr_enable <= RMC_RST_POL_EN;
    end else if (exec) begin
      unique case (cmd & RMC_OP_PORT_MASK)
        RMC_OP_LT_DISABLE: link_test_enable <= link_test_enable & ~sel;
        RMC_OP_LT_ENABLE: link_test_enable <= link_test_enable | sel;
        RMC_OP_POL_DISABLE: pol_corr_enable <= pol_corr_enable & ~sel;
        RMC_OP_POL_ENABLE: pol_corr_enable <= pol_corr_enable | sel;
        default: ;
      endcase
    end
  end

  // sticky aui flags; a new event wins over a clear in the same cycle
  logic clr_b;
  logic clr_sl;
  assign clr_b = cmd_done && port_active
    && (next_cmd == RMC_OP_AUI_ST_BSL || next_cmd == RMC_OP_AUI_ST_B);
  assign clr_sl = cmd_done && port_active
    && (next_cmd == RMC_OP_AUI_ST_BSL || next_cmd == RMC_OP_AUI_ST_SL);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_b <= 1'b0;
      flag_s <= 1'b0;
      flag_l <= 1'b0;
    end else begin
      flag_b <= aui_b_event | (flag_b & ~clr_b);
      flag_s <= aui_s_event | (flag_s & ~clr_sl);
      flag_l <= aui_l_event | (flag_l & ~clr_sl);
    end
  end
endmodule : rmc_mgmt_port

// ===== sim/rmc_mgmt_port_asserts.sv
module rmc_mgmt_port_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic test_sel,
  input wire logic sclk,
  input wire logic so,
  // watched outputs
  input wire logic aui_alt_partition,
  input wire logic tp_alt_partition,
  input wire logic aui_enable,
  input wire logic aui_part_idle,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_enable,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_part_idle,
  input wire logic [rmc_pkg::RMC_NUM_PORTS-1:0] tp_force_link_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // sclk is synchronised, so any response step except the strap-forced return high trails a sampled high
  sequence shift_seen;
    $past(sclk);
  endsequence
  // shortest legal sclk period is four clocks
  sequence start_held;
    !so [*4];
  endsequence
  so_strap_a: assert property (test_sel [*5] |-> so)
    else $error("response line active while strap high");
  so_edge_a: assert property ($changed(so) |-> shift_seen)
    else $error("response bit moved without a shift edge");
  start_bit_a: assert property ($fell(so) |-> start_held)
    else $error("start bit shorter than one shift period");
  aui_alt_hold_a: assert property (aui_alt_partition |=> aui_alt_partition)
    else $error("aui alternate partition dropped");
  tp_alt_hold_a: assert property (tp_alt_partition |=> tp_alt_partition)
    else $error("tp alternate partition dropped");
  aui_idle_pulse_a: assert property (aui_part_idle |=> !aui_part_idle)
    else $error("aui idle pulse longer than one cycle");
  aui_idle_off_a: assert property (aui_part_idle |-> !aui_enable)
    else $error("aui idled while still enabled");
  tp_idle_off_a: assert property (|tp_part_idle |-> (tp_part_idle & tp_enable) == '0)
    else $error("tp port idled while still enabled");
  link_fail_src_a: assert property (|tp_force_link_fail |->
    (tp_force_link_fail & tp_enable & ~$past(tp_enable)) == tp_force_link_fail)
    else $error("link fail forced on a port that was not disabled");
endmodule : rmc_mgmt_port_asserts

bind rmc_mgmt_port rmc_mgmt_port_asserts rmc_mgmt_port_asserts_i (.clk(clk), .rst_n(rst_n),
  .test_sel(test_sel), .sclk(sclk), .so(so), .aui_alt_partition(aui_alt_partition),
  .tp_alt_partition(tp_alt_partition), .aui_enable(aui_enable), .aui_part_idle(aui_part_idle),
  .tp_enable(tp_enable), .tp_part_idle(tp_part_idle), .tp_force_link_fail(tp_force_link_fail));

// ===== sim/rmc_ctl_model.sv
module rmc_ctl_model (
  // bench clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  // shift clock stands low and si idles high between frames
  initial begin
    sclk = 1'b0;
    si = 1'b1;
  end
  // one rise per 8 clocks; so sampled just before each rise 9..17
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [8:0] got);
    got = 9'h1ff;
    @(negedge clk);
    for (int i = 0; i < n; i++) begin
      si <= (i == 0) ? 1'b0 : (i < 9) ? cmd[i-1] : 1'b1;
      repeat (4) @(negedge clk);
      if (i >= 9 && i < 18) got[i-9] = so;
      sclk <= 1'b1;
      repeat (4) @(negedge clk);
      sclk <= 1'b0;
    end
  endtask : xfer
endmodule : rmc_ctl_model

// ===== sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic test_sel = 1'b0;
  logic aui_connected = 1'b1;
  logic [2:0] ev = 3'h0;
  logic [7:0] part = 8'ha5, rate = 8'h3c, link = 8'h96, pol = 8'h5a;
  logic sclk, si, so, so4, sqe, cam, aui_alt, tp_alt, aui_en, aui_idle;
  logic [7:0] tp_en, tp_idle, tp_lf, lt_en, pc_en, lt_en4, pc_en4;
  logic [7:0] seen_idle = 8'h00, seen_lf = 8'h00;
  logic seen_aui = 1'b0;
  int mismatches = 0, num_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  rmc_mgmt_port #(.FOUR_PORT(1'b0)) rmc_mgmt_port_i (.clk(clk), .rst_n(rst_n),
    .test_sel(test_sel), .sclk(sclk), .si(si), .so(so), .aui_connected(aui_connected),
    .aui_b_event(ev[2]), .aui_s_event(ev[1]), .aui_l_event(ev[0]), .tp_partitioned(part),
    .tp_rate_status(rate), .tp_link_status(link), .tp_pol_status(pol), .sqe_test_mask(sqe),
    .carrier_activity_monitor(cam), .aui_alt_partition(aui_alt), .tp_alt_partition(tp_alt),
    .aui_enable(aui_en), .aui_part_idle(aui_idle), .tp_enable(tp_en), .tp_part_idle(tp_idle),
    .tp_force_link_fail(tp_lf), .link_test_enable(lt_en), .pol_corr_enable(pc_en));
  rmc_ctl_model rmc_ctl_model_i (.clk(clk), .sclk(sclk), .si(si), .so(so));
  // four-port twin sees the same frames; its select decode and status read masks differ
  rmc_mgmt_port #(.FOUR_PORT(1'b1)) rmc_mgmt_port_four_i (.clk(clk), .rst_n(rst_n),
    .test_sel(test_sel), .sclk(sclk), .si(si), .so(so4), .aui_connected(aui_connected),
    .aui_b_event(ev[2]), .aui_s_event(ev[1]), .aui_l_event(ev[0]), .tp_partitioned(part),
    .tp_rate_status(rate), .tp_link_status(link), .tp_pol_status(pol), .sqe_test_mask(),
    .carrier_activity_monitor(), .aui_alt_partition(), .tp_alt_partition(), .aui_enable(),
    .aui_part_idle(), .tp_enable(), .tp_part_idle(), .tp_force_link_fail(),
    .link_test_enable(lt_en4), .pol_corr_enable(pc_en4));
  // pulses are one cycle wide, so they are gathered here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    seen_aui <= seen_aui | aui_idle;
    seen_idle <= seen_idle | tp_idle;
    seen_lf <= seen_lf | tp_lf;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] cmd);
    logic [8:0] got;
    rmc_ctl_model_i.xfer(cmd, 14, got);
    cmp(got, 9'h1ff);
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input logic [8:0] exp);
    logic [8:0] got;
    rmc_ctl_model_i.xfer(cmd, 20, got);
    cmp(got, exp);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    cmp({tp_en, so}, {RMC_RST_PORT_EN, RMC_RST_SO});
    cmp({lt_en, pc_en[0]}, {RMC_RST_LT_EN, RMC_RST_POL_EN[0]});
    cmp({pc_en, aui_en}, {RMC_RST_POL_EN, 1'b1});
    cmp({4'h0, sqe, cam, aui_alt, tp_alt, seen_aui}, 9'h000);
    test_sel = 1'b1;
    wr(RMC_OP_AUI_DISABLE);
    rd(RMC_OP_LINK_ST, 9'h1ff);
    cmp({8'h00, aui_en}, 9'h001);
    test_sel = 1'b0;
    $display("strap test done");
    wr(RMC_OP_OPTIONS | 8'h02);
    cmp({7'h0, sqe, cam}, 9'h002);
    wr(RMC_OP_OPTIONS | 8'h01);
    cmp({7'h0, sqe, cam}, 9'h001);
    wr(RMC_OP_ALT_AUI_PART);
    wr(RMC_OP_ALT_TP_PART);
    cmp({7'h0, aui_alt, tp_alt}, 9'h003);
    wr(RMC_OP_AUI_DISABLE);
    cmp({7'h0, aui_en, seen_aui}, 9'h001);
    wr(RMC_OP_AUI_ENABLE);
    cmp({8'h0, aui_en}, 9'h001);
    $display("option test done");
    for (int i = 0; i < 8; i++) begin
      wr(RMC_OP_LT_DISABLE | 8'(i));
      cmp({1'b0, lt_en}, {1'b0, 8'hfe << i});
    end
    wr(RMC_OP_LT_ENABLE | 8'h02);
    cmp({1'b0, lt_en}, 9'h004);
    wr(RMC_OP_TP_DISABLE | 8'h05);
    cmp({seen_idle, 1'b0}, {8'h20, 1'b0});
    cmp({1'b0, tp_en}, 9'h0df);
    wr(RMC_OP_TP_ENABLE | 8'h03);
    wr(RMC_OP_TP_ENABLE | 8'h05);
    cmp({seen_lf, 1'b0}, {8'h20, 1'b0});
    cmp({1'b0, tp_en}, 9'h0ff);
    wr(RMC_OP_POL_ENABLE | 8'h03);
    wr(RMC_OP_POL_ENABLE | 8'h06);
    wr(RMC_OP_POL_DISABLE | 8'h06);
    cmp({1'b0, pc_en}, 9'h008);
    cmp({so4, lt_en4}, {1'b1, 8'hf0});
    cmp({1'b0, pc_en4}, 9'h002);
    $display("port test done");
    rd(RMC_OP_PART_ST, {part, 1'b0});
    rd(RMC_OP_RATE_ST, {rate, 1'b0});
    rd(RMC_OP_LINK_ST, {link, 1'b0});
    rd(RMC_OP_POL_ST, {pol, 1'b0});
    @(negedge clk) ev = 3'h7;
    @(negedge clk) ev = 3'h0;
    rd(RMC_OP_AUI_ST_NONE, 9'h1e0);
    rd(RMC_OP_AUI_ST_B, 9'h1e0);
    rd(RMC_OP_AUI_ST_NONE, 9'h160);
    rd(RMC_OP_AUI_ST_SL, 9'h160);
    rd(RMC_OP_AUI_ST_NONE, 9'h100);
    @(negedge clk) ev = 3'h7;
    @(negedge clk) ev = 3'h0;
    rd(RMC_OP_AUI_ST_BSL, 9'h1e0);
    aui_connected = 1'b0;
    rd(RMC_OP_AUI_ST_NONE, 9'h000);
    $display("status test done");
    rd(8'hff, 9'h1ff);
    rd(8'h90, 9'h1ff);
    wr(8'h05);
    cmp({4'h0, sqe, cam, aui_alt, tp_alt, aui_en}, 9'h00f);
    $display("unassigned test done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    cmp({4'h0, sqe, cam, aui_alt, tp_alt, aui_en}, 9'h001);
    cmp({1'b0, tp_en}, {1'b0, RMC_RST_PORT_EN});
    cmp({1'b0, lt_en}, {1'b0, RMC_RST_LT_EN});
    rd(RMC_OP_AUI_ST_NONE, 9'h000);
    $display("reset test done");
    end_sim();
  end
endmodule : tb
